// ===== hctsd_top.v
// Strap decode and host command timeout supervisor, top level
`timescale 1ns/1ps
`default_nettype none
`include "hctsd_defs.vh"

// How it works
// - Link address comes from bank 1 switches; down reads 0, up reads 1.
// - Bank 2 position 9 selects the operational mode at strap capture.
// - Bank 1 positions 9 and 10 form the two-bit timeout code.
// - Code 00 gives 0 s, 01 gives 10 s, 10 gives 20 s, 11 gives 40 s.
// - Every accepted host command gets some answer within the timeout.
// - Missing secondary reply at timeout sends the host an error reply.
// - Timing is identical for legacy terminal and byte link protocols.
// - Zero timeout code rejects every host command at once.
// - Zero timeout code also selects standalone manager mode.
// - Switches are sampled once after reset and ignored afterwards.
module hctsd_top
#(
  parameter TICK_CYC = `HCTSD_TICK_NS / `HCTSD_CLK_NS
)
(
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  input  wire [9:0]              sw1_i,
  input  wire [9:0]              sw2_i,
  input  wire                    cmd_valid_i,
  input  wire [`HCTSD_TAG_W-1:0] cmd_tag_i,
  input  wire                    cmd_proto_i,
  input  wire                    reply_valid_i,
  input  wire [`HCTSD_TAG_W-1:0] reply_tag_i,
  input  wire                    psel_i,
  input  wire                    penable_i,
  input  wire                    pwrite_i,
  input  wire [7:0]              paddr_i,
  input  wire [31:0]             pwdata_i,
  output wire                    cmd_accept_o,
  output wire                    cmd_reject_o,
  output wire                    reply_fwd_o,
  output wire [`HCTSD_TAG_W-1:0] reply_tag_o,
  output wire                    err_valid_o,
  output wire [`HCTSD_TAG_W-1:0] err_tag_o,
  output wire                    err_proto_o,
  output wire [7:0]              link_addr_o,
  output wire [7:0]              serial_cfg_o,
  output wire                    op_mode_o,
  output wire                    standalone_manager_mode_o,
  output wire                    cfg_fault_o,
  output wire [1:0]              tmo_code_o,
  output wire [31:0]             prdata_o,
  output wire                    pready_o,
  output wire                    pslverr_o
);

  localparam NS = `HCTSD_NSLOT;
  localparam integer TICK_M1 = TICK_CYC - 1;
  // Cut to the divider width on purpose; TICK_CYC must fit in that many bits
  localparam [`HCTSD_DIV_W-1:0] TICK_LAST = TICK_M1[`HCTSD_DIV_W-1:0];

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Tag to one-hot slot select, used for starts and cancels
  function [NS-1:0] tag_sel;
    input [`HCTSD_TAG_W-1:0] tag;
    begin
      tag_sel = {{(NS-1){1'b0}}, 1'b1} << tag;
    end
  endfunction

  // Timeout code to limit in ticks
  function [15:0] tmo_limit;
    input [1:0] code;
    begin
      case (code)
        2'b01:   tmo_limit = `HCTSD_TMO1_MS;
        2'b10:   tmo_limit = `HCTSD_TMO2_MS;
        2'b11:   tmo_limit = `HCTSD_TMO3_MS;
        default: tmo_limit = `HCTSD_TMO0_MS;
      endcase
    end
  endfunction

  // Lowest pending slot index
  function [`HCTSD_TAG_W-1:0] first_one;
    input [NS-1:0] vec;
    integer k;
    begin
      first_one = {`HCTSD_TAG_W{1'b0}};
      for (k = NS - 1; k >= 0; k = k - 1)
        if (vec[k])
          first_one = k[`HCTSD_TAG_W-1:0];
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg                    cfg_done_ff;
  reg [7:0]              addr_ff;
  reg [7:0]              serial_ff;
  reg [1:0]              code_ff;
  reg                    mode_ff;
  reg                    alone_ff;
  reg                    fault_ff;
  reg                    ctrl_en_ff;
  reg [`HCTSD_DIV_W-1:0] div_ff;
  reg                    tick_ff;
  reg [NS-1:0]           pend_ff;
  reg [NS-1:0]           proto_ff;
  reg                    accept_ff;
  reg                    reject_ff;
  reg                    rfwd_ff;
  reg [`HCTSD_TAG_W-1:0] rtag_ff;
  reg                    err_ff;
  reg [`HCTSD_TAG_W-1:0] etag_ff;
  reg                    eproto_ff;
  reg [15:0]             err_cnt_ff;
  reg [15:0]             late_cnt_ff;
  reg                    pready_ff;
  reg                    pslverr_ff;
  reg [31:0]             prdata_ff;
  reg [31:0]             nxt_prdata;
  reg                    nxt_pslverr;
  reg [NS-1:0]           nxt_pend;
  wire [NS-1:0]          busy;
  wire [NS-1:0]          expire;
  wire [NS-1:0]          start_vec;
  wire [NS-1:0]          cancel_vec;
  wire [NS-1:0]          grant_vec;
  wire [`HCTSD_TAG_W-1:0] grant_idx;
  wire [15:0]            limit;
  wire                   cmd_ok;
  wire                   reply_hit;
  wire                   apb_setup;
  wire                   apb_wr;
  wire [31:0]            status_word;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Taken on the first edge after reset release, then frozen
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_done_ff <= 1'b0;
      addr_ff     <= 8'h00;
      serial_ff   <= 8'h00;
      code_ff     <= 2'h0;
      mode_ff     <= 1'b0;
      alone_ff    <= 1'b0;
      fault_ff    <= 1'b0;
    end
    else if (!cfg_done_ff)
    begin
      cfg_done_ff <= 1'b1;
      addr_ff     <= sw1_i[`HCTSD_SW_ADDR_MSB:0];
      serial_ff   <= sw2_i[`HCTSD_SW_SER_MSB:0];
      mode_ff     <= sw2_i[`HCTSD_SW2_MODE];
      fault_ff    <= sw2_i[`HCTSD_SW2_NORMAL];
      code_ff     <= {sw1_i[`HCTSD_SW1_TMO_HI], sw1_i[`HCTSD_SW1_TMO_LO]};
      alone_ff    <= ~(sw1_i[`HCTSD_SW1_TMO_HI] | sw1_i[`HCTSD_SW1_TMO_LO]);
    end
  end

  // Limit in ticks; code 00 never starts a timer, so its zero limit goes unused
  assign limit = tmo_limit(code_ff);

  // ----------------------------------------
  // Millisecond tick divider
  // ----------------------------------------
  // Free running, so the first tick of a command may come early by up to one tick
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_ff  <= {`HCTSD_DIV_W{1'b0}};
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (div_ff == TICK_LAST);
      if (div_ff == TICK_LAST)
        div_ff <= {`HCTSD_DIV_W{1'b0}};
      else
        div_ff <= div_ff + {{(`HCTSD_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Command admission and reply matching
  // ----------------------------------------
  // Protocol plays no part in admission or timing
  assign cmd_ok = cmd_valid_i & cfg_done_ff & ~alone_ff & ctrl_en_ff
                & ~busy[cmd_tag_i];
  assign start_vec  = cmd_ok ? tag_sel(cmd_tag_i) : {NS{1'b0}};
  assign reply_hit  = reply_valid_i & busy[reply_tag_i];
  assign cancel_vec = reply_hit ? tag_sel(reply_tag_i) : {NS{1'b0}};

  // ----------------------------------------
  // Timer slots
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1)
    begin : g_slot
      hctsd_slot_timer u_timer
      (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .tick_i    (tick_ff),
        .start_i   (start_vec[gi]),
        .cancel_i  (cancel_vec[gi]),
        .limit_i   (limit),
        .busy_o    (busy[gi]),
        .expire_o  (expire[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Error reply queue
  // ----------------------------------------
  // Several slots may expire together; one error reply leaves per cycle
  // Lowest tag first, so a higher tag may wait up to NS-1 cycles for its turn
  assign grant_idx = first_one(pend_ff);
  assign grant_vec = (|pend_ff) ? tag_sel(grant_idx) : {NS{1'b0}};

  always @*
  begin
    nxt_pend = (pend_ff & ~grant_vec) | expire;
  end

  // Host side answer pulses
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pend_ff     <= {NS{1'b0}};
      proto_ff    <= {NS{1'b0}};
      accept_ff   <= 1'b0;
      reject_ff   <= 1'b0;
      rfwd_ff     <= 1'b0;
      rtag_ff     <= {`HCTSD_TAG_W{1'b0}};
      err_ff      <= 1'b0;
      etag_ff     <= {`HCTSD_TAG_W{1'b0}};
      eproto_ff   <= 1'b0;
      err_cnt_ff  <= 16'h0000;
      late_cnt_ff <= 16'h0000;
    end
    else
    begin
      pend_ff   <= nxt_pend;
      proto_ff  <= (proto_ff & ~start_vec) | (start_vec & {NS{cmd_proto_i}});
      accept_ff <= cmd_ok;
      reject_ff <= cmd_valid_i & ~cmd_ok;
      rfwd_ff   <= reply_hit;
      rtag_ff   <= reply_tag_i;
      err_ff    <= |pend_ff;
      etag_ff   <= grant_idx;
      eproto_ff <= proto_ff[grant_idx];
      if (|pend_ff)
        err_cnt_ff <= err_cnt_ff + 16'h0001;
      // Replies after expiry are dropped; the host already has its error
      if (reply_valid_i && !reply_hit)
        late_cnt_ff <= late_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states; only CTRL takes writes, the others ignore them
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr    = psel_i & penable_i & pwrite_i & pready_ff;

  // Live busy bits beside frozen straps; busy may move between setup and access
  assign status_word = {12'h000, busy, 2'b00, cfg_done_ff, fault_ff,
                        alone_ff, mode_ff, code_ff, addr_ff};

  // Read mux, sampled in the setup cycle
  always @*
  begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (paddr_i == `HCTSD_OFS_CTRL)
      nxt_prdata[`HCTSD_CTRL_EN] = ctrl_en_ff;
    else if (paddr_i == `HCTSD_OFS_STATUS)
      nxt_prdata = pwrite_i ? 32'h0000_0000 : status_word;
    else if (paddr_i == `HCTSD_OFS_SERIAL)
      nxt_prdata[7:0] = pwrite_i ? 8'h00 : serial_ff;
    else if (paddr_i == `HCTSD_OFS_COUNT)
      nxt_prdata = pwrite_i ? 32'h0000_0000 : {late_cnt_ff, err_cnt_ff};
    else
      nxt_pslverr = 1'b1;
  end

  // One wait-free access phase; writes land at its closing edge
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      ctrl_en_ff <= `HCTSD_CTRL_RST;
    end
    else
    begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & nxt_pslverr;
      prdata_ff  <= apb_setup ? nxt_prdata : 32'h0000_0000;
      if (apb_wr && (paddr_i == `HCTSD_OFS_CTRL))
        ctrl_en_ff <= pwdata_i[`HCTSD_CTRL_EN];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flip-flop, so no decode glitch reaches the pins
  assign cmd_accept_o              = accept_ff;
  assign cmd_reject_o              = reject_ff;
  assign reply_fwd_o               = rfwd_ff;
  assign reply_tag_o               = rtag_ff;
  assign err_valid_o               = err_ff;
  assign err_tag_o                 = etag_ff;
  assign err_proto_o               = eproto_ff;
  assign link_addr_o               = addr_ff;
  assign serial_cfg_o              = serial_ff;
  assign op_mode_o                 = mode_ff;
  assign standalone_manager_mode_o = alone_ff;
  assign cfg_fault_o               = fault_ff;
  assign tmo_code_o                = code_ff;
  assign prdata_o                  = prdata_ff;
  assign pready_o                  = pready_ff;
  assign pslverr_o                 = pslverr_ff;

endmodule // hctsd_top
`default_nettype wire

// ===== hctsd_defs.vh
// Constants for the strap decode and host command timeout block
`ifndef HCTSD_DEFS_VH
`define HCTSD_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define HCTSD_CLK_NS      4
`define HCTSD_TICK_NS     1000000
`define HCTSD_DIV_W       18
`define HCTSD_TMO0_MS     16'h0000
`define HCTSD_TMO1_MS     16'h2710
`define HCTSD_TMO2_MS     16'h4E20
`define HCTSD_TMO3_MS     16'h9C40

// ----------------------------------------
// Switch bank bit positions (index = position - 1)
// ----------------------------------------
`define HCTSD_SW_ADDR_MSB 7
`define HCTSD_SW_SER_MSB  7
`define HCTSD_SW1_TMO_HI  8
`define HCTSD_SW1_TMO_LO  9
`define HCTSD_SW2_MODE    8
`define HCTSD_SW2_NORMAL  9

// ----------------------------------------
// Command slots
// ----------------------------------------
`define HCTSD_NSLOT       4
`define HCTSD_TAG_W       2

// ----------------------------------------
// Register offsets, fields and reset values
// ----------------------------------------
`define HCTSD_OFS_CTRL    8'h00
`define HCTSD_OFS_STATUS  8'h04
`define HCTSD_OFS_SERIAL  8'h08
`define HCTSD_OFS_COUNT   8'h0C
`define HCTSD_CTRL_EN     0
`define HCTSD_CTRL_RST    1'b1
`define HCTSD_ST_CODE_LO  8
`define HCTSD_ST_MODE     10
`define HCTSD_ST_ALONE    11
`define HCTSD_ST_FAULT    12
`define HCTSD_ST_CFG      13
`define HCTSD_ST_BUSY_LO  16

`endif

// ===== hctsd_slot_timer.v
// One host command response timer slot
`timescale 1ns/1ps
`default_nettype none
`include "hctsd_defs.vh"

module hctsd_slot_timer
(
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        tick_i,
  input  wire        start_i,
  input  wire        cancel_i,
  input  wire [15:0] limit_i,
  output wire        busy_o,
  output wire        expire_o
);

  reg        busy_ff;
  reg        expire_ff;
  reg [15:0] cnt_ff;
  wire [15:0] nxt_cnt;

  assign nxt_cnt  = cnt_ff + 16'h0001;
  assign busy_o   = busy_ff;
  assign expire_o = expire_ff;

  // ----------------------------------------
  // Tick counter per command
  // ----------------------------------------
  // Cancel beats expiry: a reply seen in the last tick still counts as in time
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_ff   <= 1'b0;
      expire_ff <= 1'b0;
      cnt_ff    <= 16'h0000;
    end
    else
    begin
      expire_ff <= 1'b0;
      if (start_i)
      begin
        busy_ff <= 1'b1;
        cnt_ff  <= 16'h0000;
      end
      else if (busy_ff && cancel_i)
        busy_ff <= 1'b0;
      else if (busy_ff && tick_i)
      begin
        if (nxt_cnt >= limit_i)
        begin
          busy_ff   <= 1'b0;
          expire_ff <= 1'b1;
        end
        else
          cnt_ff <= nxt_cnt;
      end
    end
  end

endmodule // hctsd_slot_timer
`default_nettype wire

// ===== hctsd_assertions.sv
// Checker for strap capture and command timing
`timescale 1ns/1ps
`default_nettype none
module hctsd_checker
(
  input wire       clk_i,
  input wire       reset_n_i,
  input wire [9:0] sw1_i,
  input wire [9:0] sw2_i,
  input wire       cmd_valid_i,
  input wire       reply_valid_i,
  input wire [1:0] reply_tag_i,
  input wire       psel_i,
  input wire       penable_i,
  input wire       cmd_accept_o,
  input wire       cmd_reject_o,
  input wire       reply_fwd_o,
  input wire [1:0] reply_tag_o,
  input wire       err_valid_o,
  input wire [7:0] link_addr_o,
  input wire [7:0] serial_cfg_o,
  input wire       op_mode_o,
  input wire       standalone_manager_mode_o,
  input wire [1:0] tmo_code_o,
  input wire       pready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // Strap capture, one edge after release
  // ----------------------------------------
  sequence settled_s;
    reset_n_i [*3];
  endsequence
  strap_addr_a: assert property ($rose(reset_n_i) |=> link_addr_o == $past(sw1_i[7:0]))
    else $error("link address not taken from bank 1");
  strap_mode_a: assert property ($rose(reset_n_i) |=> op_mode_o == $past(sw2_i[8]))
    else $error("mode not taken from bank 2");
  strap_code_a: assert property ($rose(reset_n_i) |=> tmo_code_o == {$past(sw1_i[8]), $past(sw1_i[9])})
    else $error("timeout code not taken from bank 1");
  strap_hold_a: assert property (settled_s |-> $stable({link_addr_o, serial_cfg_o, op_mode_o, tmo_code_o}))
    else $error("strap outputs moved in service");
  alone_code_a: assert property (settled_s |-> standalone_manager_mode_o == (tmo_code_o == 2'h0))
    else $error("standalone mode disagrees with code");
  // ----------------------------------------
  // Command, reply, error and APB ready answers
  // ----------------------------------------
  cmd_answer_a: assert property (cmd_valid_i |=> cmd_accept_o != cmd_reject_o)
    else $error("command not answered once");
  zero_reject_a: assert property (cmd_valid_i && tmo_code_o == 2'h0 |=> cmd_reject_o)
    else $error("command taken with zero code");
  reply_pair_a: assert property (reply_fwd_o |-> $past(reply_valid_i) && reply_tag_o == $past(reply_tag_i))
    else $error("forwarded reply without matching input");
  err_code_a: assert property (err_valid_o |-> tmo_code_o != 2'h0)
    else $error("error reply in standalone mode");
  apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access phase");
endmodule // hctsd_checker
bind hctsd_top hctsd_checker hctsd_checker_inst (.*);
`default_nettype wire

// ===== hctsd_sec_model.sv
// Secondary device model answering forwarded commands
`timescale 1ns/1ps
`default_nettype none
module hctsd_sec_model
(
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        mute_i,
  input  wire [7:0]  delay_i,
  input  wire        cmd_valid_i,
  input  wire [1:0]  cmd_tag_i,
  input  wire        cmd_accept_i,
  output logic       reply_valid_o,
  output logic [1:0] reply_tag_o
);
  logic [1:0] tag_ff;
  logic [7:0] cnt_ff;
  logic       run_ff;
  // One reply in flight; idle tag toggles so a stale tag never matches
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tag_ff <= 2'h0;
      cnt_ff <= 8'h00;
      run_ff <= 1'b0;
      reply_valid_o <= 1'b0;
      reply_tag_o <= 2'h0;
    end
    else
    begin
      reply_valid_o <= 1'b0;
      reply_tag_o <= ~reply_tag_o;
      if (cmd_valid_i)
        tag_ff <= cmd_tag_i;
      if (cmd_accept_i && !mute_i)
      begin
        run_ff <= 1'b1;
        cnt_ff <= delay_i;
      end
      else if (run_ff && cnt_ff == 8'h00)
      begin
        run_ff <= 1'b0;
        reply_valid_o <= 1'b1;
        reply_tag_o <= tag_ff;
      end
      else if (run_ff)
        cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule // hctsd_sec_model
`default_nettype wire

// ===== test_host_cmd_timeout_strap_decode.sv
// Self-checking bench for strap decode and command timeout
`timescale 1ns/1ps
`default_nettype none
`include "hctsd_defs.vh"
module test_host_cmd_timeout_strap_decode;
  typedef struct packed {logic [9:0] s1; logic [9:0] s2; logic [1:0] code;} hctsd_row_t;
  logic clk_i, reset_n_i, cmd_valid_i, cmd_proto_i, psel_i, penable_i, pwrite_i, mute, er;
  logic [9:0] sw1_i, sw2_i;
  logic [1:0] cmd_tag_i, reply_tag_i, reply_tag_o, err_tag_o, tmo_code_o;
  logic [7:0] paddr_i, dly, link_addr_o, serial_cfg_o;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic reply_valid_i, cmd_accept_o, cmd_reject_o, reply_fwd_o, err_valid_o, err_proto_o;
  logic op_mode_o, standalone_manager_mode_o, cfg_fault_o, pready_o, pslverr_o;
  hctsd_row_t rows [0:3];
  int num_errors, n_compared, cycles, i, n;

  hctsd_top #(.TICK_CYC(4)) hctsd_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .sw1_i(sw1_i),
    .sw2_i(sw2_i), .cmd_valid_i(cmd_valid_i), .cmd_tag_i(cmd_tag_i), .cmd_proto_i(cmd_proto_i),
    .reply_valid_i(reply_valid_i), .reply_tag_i(reply_tag_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .cmd_accept_o(cmd_accept_o),
    .cmd_reject_o(cmd_reject_o), .reply_fwd_o(reply_fwd_o), .reply_tag_o(reply_tag_o),
    .err_valid_o(err_valid_o), .err_tag_o(err_tag_o), .err_proto_o(err_proto_o), .link_addr_o(link_addr_o),
    .serial_cfg_o(serial_cfg_o), .op_mode_o(op_mode_o), .standalone_manager_mode_o(standalone_manager_mode_o),
    .cfg_fault_o(cfg_fault_o), .tmo_code_o(tmo_code_o), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));
  hctsd_sec_model hctsd_sec_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .mute_i(mute), .delay_i(dly),
    .cmd_valid_i(cmd_valid_i), .cmd_tag_i(cmd_tag_i), .cmd_accept_i(cmd_accept_o),
    .reply_valid_o(reply_valid_i), .reply_tag_o(reply_tag_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset held 20 cycles, then two edges for strap capture
  task do_reset(input logic [9:0] s1, input logic [9:0] s2);
    @(posedge clk_i);
    sw1_i <= s1;
    sw2_i <= s2;
    reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task send(input logic [1:0] t, input logic p);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_tag_i <= t;
    cmd_proto_i <= p;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask
  // Bounded wait on error (sel 1) or forwarded reply (sel 0)
  task wait_out(input int sel, input int lim, output int k);
    k = 0;
    while ((sel ? err_valid_o : reply_fwd_o) !== 1'b1 && k < lim)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Expiry test alone needs about 40000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset_n_i, cmd_valid_i, cmd_proto_i, psel_i, penable_i, pwrite_i, mute} = 7'h00;
    {sw1_i, sw2_i, cmd_tag_i, paddr_i, pwdata_i, dly} = 70'h0;
    // Bank 2 position 10 set in the last row on purpose
    rows = '{'{10'h0A5, 10'h013, 2'h0}, '{10'h25A, 10'h1C3, 2'h1}, '{10'h1FF, 10'h000, 2'h2},
             '{10'h301, 10'h200, 2'h3}};
    for (i = 0; i < 4; i++)
    begin
      dly <= 8'(i * 12);
      do_reset(rows[i].s1, rows[i].s2);
      chk("code", rows[i].code, tmo_code_o);
      chk("standalone", rows[i].code == 2'h0, standalone_manager_mode_o);
      chk("addr", rows[i].s1[7:0], link_addr_o);
      chk("serial", rows[i].s2[7:0], serial_cfg_o);
      chk("mode", rows[i].s2[8], op_mode_o);
      chk("fault", rows[i].s2[9], cfg_fault_o);
      send(2'(i), 1'(i));
      chk("reject", rows[i].code == 2'h0, cmd_reject_o);
      wait_out(0, 80, n);
      chk("fwd", rows[i].code != 2'h0, reply_fwd_o);
      if (rows[i].code != 2'h0)
        chk("fwd tag", i, reply_tag_o);
    end
    do_reset(10'h25A, 10'h0C3);
    @(posedge clk_i);
    sw1_i <= 10'h3FF;
    sw2_i <= 10'h3FF;
    repeat (3) @(posedge clk_i);
    #1;
    chk("held code", 1, tmo_code_o);
    chk("held addr", 8'h5A, link_addr_o);
    apb(1'b0, `HCTSD_OFS_STATUS, 0);
    chk("status", 32'h0000215A, rd);
    apb(1'b0, `HCTSD_OFS_SERIAL, 0);
    chk("serial reg", 32'h000000C3, rd);
    apb(1'b0, 8'h10, 0);
    chk("unmapped", 1, er);
    apb(1'b1, `HCTSD_OFS_CTRL, 0);
    send(2'h0, 1'b0);
    chk("off reject", 1, cmd_reject_o);
    apb(1'b1, `HCTSD_OFS_CTRL, 1);
    apb(1'b0, `HCTSD_OFS_CTRL, 0);
    chk("ctrl", 1, rd);
    mute <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_tag_i <= 2'h2;
    cmd_proto_i <= 1'b1;
    @(posedge clk_i);
    cmd_tag_i <= 2'h3;
    cmd_proto_i <= 1'b0;
    #1 chk("accept 2", 1, cmd_accept_o);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1 chk("accept 3", 1, cmd_accept_o);
    send(2'h2, 1'b1);
    chk("busy reject", 1, cmd_reject_o);
    wait_out(1, 41000, n);
    chk("expiry time", 1, n > 39985 && n < 40010);
    chk("err tag", 2, err_tag_o);
    chk("err proto", 1, err_proto_o);
    @(posedge clk_i);
    #1;
    wait_out(1, 8, n);
    chk("err tag", 3, err_tag_o);
    chk("err proto", 0, err_proto_o);
    apb(1'b0, `HCTSD_OFS_COUNT, 0);
    chk("count", 2, rd[15:0]);
    finish_test();
  end
endmodule // test_host_cmd_timeout_strap_decode
`default_nettype wire
